/* File: sal_ctl.sv */
/*
 Memory controller end: makes the command clock by a divider, issues one
 command at a time, honours parity latency, refresh periods, leveling waits
 and the persistent-parity deselect duty.
 Assumes the user holds a request until req_ready is seen with it.
*/
`timescale 1ns/1ps
module sal_ctl
    import sal_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic [CMD_W-1:0] req_cmd,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic req_par_err,
    input wire logic req_sum_err,
    input wire logic [1:0] rfc_mode,
    input wire logic persist_en,
    sal_link_if.ctl link,
    output logic req_ready,
    output logic done,
    output logic done_err,
    output logic lvl_result
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_HOLD,
        ST_WAIT,
        ST_LVL
    } sal_state_t;

    sal_state_t st_q, st_d;
    logic [$clog2(CK_HALF)-1:0] div_q, div_d;
    logic ck_q, ck_d, fall, div_end;
    logic al1_q, al2_q, alert_seen;
    logic [CMD_W-1:0] pend_q, pend_d, cmd_q, cmd_d;
    logic [DATA_W-1:0] pwd_q, pwd_d, wd_q, wd_d;
    logic pinj_q, pinj_d, sinj_q, sinj_d;
    logic par_q, par_d;
    logic [SUM_W-1:0] ws_q, ws_d;
    logic dqs_q, dqs_d, dlv_q, dlv_d;
    logic [7:0] cnt_q, cnt_d;
    logic rdy_q, rdy_d, done_q, done_d, err_q, err_d, res_q, res_d;

    // nCK to wait after a command before the next one
    function automatic logic [7:0] wait_target(input logic [CMD_W-1:0] c,
                                               input logic [1:0] m);
        wait_target = 8'(PARITY_LATENCY + 1);
        if (c == CMD_REF) begin
            case (m)
                RFC_DOUBLE: wait_target = 8'(REFRESH_PERIOD_DOUBLE_NCK);
                RFC_QUAD: wait_target = 8'(REFRESH_PERIOD_QUAD_NCK);
                default: wait_target = 8'(REFRESH_PERIOD_NORMAL_NCK);
            endcase
            if (wait_target < 8'(PARITY_LATENCY + 1)) begin
                wait_target = 8'(PARITY_LATENCY + 1);
            end
        end
    endfunction

    // Alert pin synchroniser
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            al1_q <= 1'h1;
            al2_q <= 1'h1;
        end else begin
            al1_q <= link.alert_n;
            al2_q <= al1_q;
        end
    end

    assign alert_seen = ~al2_q;
    assign div_end = div_q == ($clog2(CK_HALF))'(CK_HALF - 1);
    assign fall = div_end & ck_q;

    // Clock divider and command sequencer
    always_comb begin
        div_d = div_end ? '0 : div_q + 1'h1;
        ck_d = div_end ? ~ck_q : ck_q;
        st_d = st_q;
        pend_d = pend_q;
        pwd_d = pwd_q;
        pinj_d = pinj_q;
        sinj_d = sinj_q;
        cmd_d = cmd_q;
        par_d = par_q;
        wd_d = wd_q;
        ws_d = ws_q;
        dqs_d = dqs_q;
        dlv_d = dlv_q;
        cnt_d = cnt_q;
        rdy_d = rdy_q;
        done_d = 1'h0;
        err_d = err_q;
        res_d = res_q;
        case (st_q)
            ST_IDLE: begin
                // Hold off new work while a persistent alert stands
                rdy_d = !(persist_en && alert_seen);
                if (req_valid && rdy_q) begin
                    pend_d = req_cmd;
                    pwd_d = req_wdata;
                    pinj_d = req_par_err;
                    sinj_d = req_sum_err;
                    rdy_d = 1'h0;
                    err_d = 1'h0;
                    st_d = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                if (fall) begin
                    // Deselect replaces the command under persistent alert
                    cmd_d = (persist_en && alert_seen) ? CMD_DES : pend_q;
                    par_d = cmd_parity(cmd_d) ^ pinj_q;
                    wd_d = pwd_q;
                    ws_d = data_checksum(pwd_q) ^ (sinj_q ? 4'hF : 4'h0);
                    err_d = persist_en && alert_seen;
                    cnt_d = 8'h0;
                    st_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (fall) begin
                    cmd_d = CMD_DES;
                    par_d = cmd_parity(CMD_DES);
                    cnt_d = 8'h1;
                    st_d = (cmd_q == CMD_WLEV) ? ST_LVL : ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Outcome unknown until parity latency has passed
                if (alert_seen) begin
                    err_d = 1'h1;
                end
                if (fall) begin
                    cnt_d = cnt_q + 8'h1;
                    if (cnt_q >= wait_target(cmd_q == CMD_DES ? pend_q : cmd_q,
                                             rfc_mode)) begin
                        done_d = 1'h1;
                        st_d = ST_IDLE;
                    end
                end
            end
            ST_LVL: begin
                if (fall) begin
                    cnt_d = cnt_q + 8'h1;
                    if (cnt_q == 8'(LEVELING_STROBE_DRIVE_WAIT + 1)) begin
                        dlv_d = 1'h1;
                    end
                    if (cnt_q == 8'(LEVELING_FIRST_STROBE_WAIT + 1)) begin
                        dqs_d = 1'h1;
                    end
                    if (cnt_q == 8'(LEVELING_FIRST_STROBE_WAIT + 2)) begin
                        dqs_d = 1'h0;
                    end
                    if (cnt_q == 8'(LEVELING_FIRST_STROBE_WAIT + 4)) begin
                        res_d = link.dq_fb;
                        dlv_d = 1'h0;
                        done_d = 1'h1;
                        st_d = ST_IDLE;
                    end
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            div_q <= '0;
            ck_q <= 1'h0;
            pend_q <= '0;
            pwd_q <= '0;
            pinj_q <= 1'h0;
            sinj_q <= 1'h0;
            cmd_q <= '0;
            par_q <= 1'h0;
            wd_q <= '0;
            ws_q <= '0;
            dqs_q <= 1'h0;
            dlv_q <= 1'h0;
            cnt_q <= 8'h0;
            rdy_q <= 1'h0;
            done_q <= 1'h0;
            err_q <= 1'h0;
            res_q <= 1'h0;
        end else begin
            st_q <= st_d;
            div_q <= div_d;
            ck_q <= ck_d;
            pend_q <= pend_d;
            pwd_q <= pwd_d;
            pinj_q <= pinj_d;
            sinj_q <= sinj_d;
            cmd_q <= cmd_d;
            par_q <= par_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            dqs_q <= dqs_d;
            dlv_q <= dlv_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            done_q <= done_d;
            err_q <= err_d;
            res_q <= res_d;
        end
    end

    // Link and user outputs straight from flops
    assign link.ck = ck_q;
    assign link.cmd = cmd_q;
    assign link.par = par_q;
    assign link.wdata = wd_q;
    assign link.wsum = ws_q;
    assign link.dqs = dqs_q;
    assign link.dqs_lvl = dlv_q;
    assign req_ready = rdy_q;
    assign done = done_q;
    assign done_err = err_q;
    assign lvl_result = res_q;
endmodule

/* File: sal_pkg.sv */
/*
 Shared constants, command codes and helper functions for the SDRAM alert and
 write-leveling link. Both ends import it whole. Assumes a 40 MHz system clock
 and a command clock made by the controller from it.
*/
// Functional notes
// - Controller waits 40 nCK before first strobe rise
// - Controller waits 25 nCK before driving strobe leveling
// - Commands after parity error may be dropped
// - Parity alert asserts within latency plus 6 ns
// - Parity alert lasts 56 to 128 nCK
// - Persistent mode: controller sends deselects within 57
// - Checksum alert pulse lasts 6 to 10 nCK
// - Checksum alert asserts 3 to 13 ns later; device drives it one 25 ns system cycle after synchronised detection
package sal_pkg;

    // System clock and command clock divider
    localparam int CLK_PERIOD_NS = 25;
    localparam int CK_HALF = 2;
    localparam int CK_PERIOD_NS = 2 * CK_HALF * CLK_PERIOD_NS;

    // Link timing in command clock cycles (nCK)
    localparam int PARITY_LATENCY = 4;
    localparam int LEVELING_FIRST_STROBE_WAIT = 40;
    localparam int LEVELING_STROBE_DRIVE_WAIT = 25;
    localparam int PARITY_ALERT_WIDTH_MIN = 56;
    localparam int PARITY_ALERT_WIDTH_MAX = 128;
    localparam int PARITY_ALERT_WIDTH = 64;
    localparam int PARITY_ALERT_RESPONSE_TIME = 57;
    localparam int CHECKSUM_ALERT_WIDTH_MIN = 6;
    localparam int CHECKSUM_ALERT_WIDTH_MAX = 10;
    localparam int CHECKSUM_ALERT_WIDTH = 8;

    // Times in ns and the cycle counts derived from them
    localparam int PARITY_ALERT_DELAY_NS = 6;
    localparam int CHECKSUM_ALERT_DELAY_MIN_NS = 3;
    localparam int CHECKSUM_ALERT_DELAY_MAX_NS = 13;
    localparam int CHECKSUM_ALERT_DELAY_CYC =
        (CHECKSUM_ALERT_DELAY_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (CHECKSUM_ALERT_DELAY_MAX_NS / CLK_PERIOD_NS);
    localparam int REFRESH_PERIOD_NORMAL_NS = 260;
    localparam int REFRESH_PERIOD_DOUBLE_NS = 160;
    localparam int REFRESH_PERIOD_QUAD_NS = 110;
    localparam int REFRESH_PERIOD_NORMAL_NCK =
        (REFRESH_PERIOD_NORMAL_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
    localparam int REFRESH_PERIOD_DOUBLE_NCK =
        (REFRESH_PERIOD_DOUBLE_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
    localparam int REFRESH_PERIOD_QUAD_NCK =
        (REFRESH_PERIOD_QUAD_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS;

    // Refresh granularity selector values
    localparam logic [1:0] RFC_NORMAL = 2'h0;
    localparam logic [1:0] RFC_DOUBLE = 2'h1;
    localparam logic [1:0] RFC_QUAD = 2'h2;

    // Widths of link fields and packed synchroniser vector
    localparam int CMD_W = 3;
    localparam int DATA_W = 8;
    localparam int SUM_W = 4;
    localparam int LINK_IN_W = 1 + CMD_W + 1 + DATA_W + SUM_W + 1 + 1;

    // Command codes on the link
    typedef enum logic [2:0] {
        CMD_DES = 3'h0,
        CMD_ACT = 3'h1,
        CMD_RD = 3'h2,
        CMD_WR = 3'h3,
        CMD_REF = 3'h4,
        CMD_WLEV = 3'h5,
        CMD_WLEX = 3'h6,
        CMD_PRE = 3'h7
    } sal_cmd_t;

    // Even parity over the command bits
    function automatic logic cmd_parity(input logic [CMD_W-1:0] cmd);
        cmd_parity = ^cmd;
    endfunction

    // Write data checksum: nibble fold
    function automatic logic [SUM_W-1:0] data_checksum(input logic [DATA_W-1:0] d);
        data_checksum = d[7:4] ^ d[3:0];
    endfunction

endpackage

/* File: sal_link_if.sv */
/*
 Link between the memory controller and the SDRAM device end.
 Assumes the open-drain alert line is pulled high when nobody drives it.
*/
`timescale 1ns/1ps
interface sal_link_if;
    import sal_pkg::*;
    logic ck;
    logic [CMD_W-1:0] cmd;
    logic par;
    logic [DATA_W-1:0] wdata;
    logic [SUM_W-1:0] wsum;
    logic dqs;
    logic dqs_lvl;
    logic dq_fb;
    logic alert_o;
    logic alert_oe;
    wire alert_n;

    // Open-drain resolution, enable low means driving
    assign alert_n = alert_oe ? 1'h1 : alert_o;

    modport dev (
        input ck, cmd, par, wdata, wsum, dqs, dqs_lvl,
        output dq_fb, alert_o, alert_oe
    );
    modport ctl (
        output ck, cmd, par, wdata, wsum, dqs, dqs_lvl,
        input dq_fb, alert_n
    );
endinterface

/* File: sal_dev.sv */
/*
 SDRAM device end: parity check with delayed execution, alert pulses for
 parity and write checksum errors, write-leveling feedback.
 Assumes the controller changes link outputs on falling command clock edges.
*/
`timescale 1ns/1ps
module sal_dev
    import sal_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic persist_en,
    sal_link_if.dev link,
    output logic exec_valid,
    output logic [CMD_W-1:0] exec_cmd,
    output logic [DATA_W-1:0] exec_wdata,
    output logic lvl_active,
    output logic alert_active
);
    logic [LINK_IN_W-1:0] s1_q, s2_q;
    logic ck_prev_q, dqs_prev_q;
    logic ck_s, par_s, dqs_s, lvl_s, rise, dqs_rise, par_ok, sum_ok, take;
    logic [CMD_W-1:0] cmd_s;
    logic [DATA_W-1:0] wd_s;
    logic [SUM_W-1:0] ws_s;
    logic pv_q [PARITY_LATENCY], pv_d [PARITY_LATENCY];
    logic [CMD_W-1:0] pc_q [PARITY_LATENCY], pc_d [PARITY_LATENCY];
    logic [DATA_W-1:0] pw_q [PARITY_LATENCY], pw_d [PARITY_LATENCY];
    logic [7:0] par_cnt_q, par_cnt_d, crc_cnt_q, crc_cnt_d;
    logic [2:0] block_q, block_d;
    logic lvl_q, lvl_d, fb_q, fb_d, oe_q, oe_d;
    logic ev_q, ev_d;
    logic act_q;
    logic [CMD_W-1:0] ec_q, ec_d;
    logic [DATA_W-1:0] ew_q, ew_d;

    // Two-stage synchroniser for every link input
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            ck_prev_q <= 1'h0;
            dqs_prev_q <= 1'h0;
        end else begin
            s1_q <= {link.ck, link.cmd, link.par, link.wdata, link.wsum,
                     link.dqs, link.dqs_lvl};
            s2_q <= s1_q;
            ck_prev_q <= ck_s;
            dqs_prev_q <= dqs_s;
        end
    end

    assign {ck_s, cmd_s, par_s, wd_s, ws_s, dqs_s, lvl_s} = s2_q;
    assign rise = ck_s & ~ck_prev_q;
    assign dqs_rise = dqs_s & ~dqs_prev_q;
    assign par_ok = cmd_parity(cmd_s) == par_s;
    assign sum_ok = data_checksum(wd_s) == ws_s;
    // Drop errant command, its shadow and anything under a persistent alert
    assign take = (cmd_s != CMD_DES) && par_ok && (block_q == 3'h0) &&
                  !(persist_en && (par_cnt_q != 8'h0)) &&
                  !((cmd_s == CMD_WR) && !sum_ok);

    // Command pipeline, alert timers and leveling feedback
    always_comb begin
        for (int i = 0; i < PARITY_LATENCY; i++) begin
            pv_d[i] = pv_q[i];
            pc_d[i] = pc_q[i];
            pw_d[i] = pw_q[i];
        end
        par_cnt_d = par_cnt_q;
        crc_cnt_d = crc_cnt_q;
        block_d = block_q;
        lvl_d = lvl_q;
        fb_d = fb_q;
        ev_d = 1'h0;
        ec_d = ec_q;
        ew_d = ew_q;
        if (rise) begin
            // Execution delayed by the parity latency
            ev_d = pv_q[PARITY_LATENCY-1];
            ec_d = pc_q[PARITY_LATENCY-1];
            ew_d = pw_q[PARITY_LATENCY-1];
            for (int i = PARITY_LATENCY - 1; i > 0; i--) begin
                pv_d[i] = pv_q[i-1];
                pc_d[i] = pc_q[i-1];
                pw_d[i] = pw_q[i-1];
            end
            pv_d[0] = take;
            pc_d[0] = cmd_s;
            pw_d[0] = wd_s;
            if (par_cnt_q != 8'h0) begin
                par_cnt_d = par_cnt_q - 8'h1;
            end
            if (crc_cnt_q != 8'h0) begin
                crc_cnt_d = crc_cnt_q - 8'h1;
            end
            if (block_q != 3'h0) begin
                block_d = block_q - 3'h1;
            end
            if (!par_ok) begin
                par_cnt_d = 8'(PARITY_ALERT_WIDTH);
                block_d = 3'(PARITY_LATENCY);
            end else if ((cmd_s == CMD_WR) && !sum_ok) begin
                crc_cnt_d = 8'(CHECKSUM_ALERT_WIDTH);
            end
            // Leveling mode follows executed mode commands
            if (pv_q[PARITY_LATENCY-1] && (pc_q[PARITY_LATENCY-1] == CMD_WLEV)) begin
                lvl_d = 1'h1;
            end
            if (pv_q[PARITY_LATENCY-1] && (pc_q[PARITY_LATENCY-1] == CMD_WLEX)) begin
                lvl_d = 1'h0;
            end
        end
        // Report clock level seen at strobe rise
        if (lvl_q && lvl_s && dqs_rise) begin
            fb_d = ck_s;
        end
        // Alert driven one system cycle after detection
        oe_d = (par_cnt_d == 8'h0) && (crc_cnt_d == 8'h0);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < PARITY_LATENCY; i++) begin
                pv_q[i] <= 1'h0;
                pc_q[i] <= '0;
                pw_q[i] <= '0;
            end
            par_cnt_q <= 8'h0;
            crc_cnt_q <= 8'h0;
            block_q <= 3'h0;
            lvl_q <= 1'h0;
            fb_q <= 1'h0;
            oe_q <= 1'h1;
            act_q <= 1'h0;
            ev_q <= 1'h0;
            ec_q <= '0;
            ew_q <= '0;
        end else begin
            pv_q <= pv_d;
            pc_q <= pc_d;
            pw_q <= pw_d;
            par_cnt_q <= par_cnt_d;
            crc_cnt_q <= crc_cnt_d;
            block_q <= block_d;
            lvl_q <= lvl_d;
            fb_q <= fb_d;
            oe_q <= oe_d;
            act_q <= ~oe_d;
            ev_q <= ev_d;
            ec_q <= ec_d;
            ew_q <= ew_d;
        end
    end

    // Outputs straight from flops, except alert_o which is tied low
    assign link.dq_fb = fb_q;
    assign link.alert_o = 1'h0;
    assign link.alert_oe = oe_q;
    assign exec_valid = ev_q;
    assign exec_cmd = ec_q;
    assign exec_wdata = ew_q;
    assign lvl_active = lvl_q;
    assign alert_active = act_q;
endmodule

/* File: sal_link_chk.sv */
/*
 Checker on the link between controller and device ends.
 Assumes one instance beside the interface, on the system clock.
*/
`timescale 1ns/1ps
module sal_link_chk
    import sal_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic persist_en,
    input wire logic ck,
    input wire logic [CMD_W-1:0] cmd,
    input wire logic par,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [SUM_W-1:0] wsum,
    input wire logic dqs,
    input wire logic dqs_lvl,
    input wire logic alert_n
);
    localparam int NCK = 2 * CK_HALF;
    logic ck_q, kind_q, kind_d, rise, perr, serr;
    logic [9:0] low_q, low_d, lev_q, lev_d, ref_q, ref_d, al_q, al_d;

    // Command clock rise and error detection at that rise
    assign rise = ck && !ck_q;
    assign perr = rise && (par != ^cmd);
    assign serr = rise && (par == ^cmd) && (cmd == CMD_WR) && (wsum != (wdata[7:4] ^ wdata[3:0]));

    // Saturating increment so idle counts never wrap
    function automatic logic [9:0] sat(input logic [9:0] v);
        sat = (v == 10'h3FF) ? v : v + 10'h1;
    endfunction

    // Next values of the watch counters
    always_comb begin
        low_d = alert_n ? 10'h0 : sat(low_q);
        al_d = alert_n ? 10'h0 : al_q;
        lev_d = lev_q;
        ref_d = ref_q;
        kind_d = kind_q;
        if (rise) begin
            lev_d = (cmd == CMD_WLEV) ? 10'h0 : sat(lev_q);
            ref_d = (cmd == CMD_REF) ? 10'h0 : sat(ref_q);
            if (!alert_n) al_d = sat(al_q);
        end
        if (perr) kind_d = 1'h1;
        else if (serr) kind_d = 1'h0;
    end

    // Counter registers, idle gaps start saturated
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ck_q <= 1'h0;
            kind_q <= 1'h0;
            low_q <= 10'h0;
            al_q <= 10'h0;
            lev_q <= 10'h3FF;
            ref_q <= 10'h3FF;
        end else begin
            ck_q <= ck;
            kind_q <= kind_d;
            low_q <= low_d;
            al_q <= al_d;
            lev_q <= lev_d;
            ref_q <= ref_d;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_strobe_first; $rose(dqs) |-> lev_q >= 10'h28; endproperty
    a_strobe_first: assert property (p_strobe_first)
        else $error("strobe rose too soon after leveling entry");
    property p_strobe_drive; $rose(dqs_lvl) |-> lev_q >= 10'h19; endproperty
    a_strobe_drive: assert property (p_strobe_drive)
        else $error("strobe leveling state driven too soon");
    property p_par_on; perr |-> ##[1:16] !alert_n; endproperty
    a_par_on: assert property (p_par_on)
        else $error("no alert after bad command parity");
    property p_par_width;
        $rose(alert_n) && kind_q |->
            low_q >= PARITY_ALERT_WIDTH_MIN * NCK && low_q <= PARITY_ALERT_WIDTH_MAX * NCK;
    endproperty
    a_par_width: assert property (p_par_width)
        else $error("parity alert width out of range");
    property p_sum_on; serr |-> ##[1:5] !alert_n; endproperty
    a_sum_on: assert property (p_sum_on)
        else $error("no alert after bad write checksum");
    property p_sum_width;
        $rose(alert_n) && !kind_q |->
            low_q >= CHECKSUM_ALERT_WIDTH_MIN * NCK && low_q <= CHECKSUM_ALERT_WIDTH_MAX * NCK;
    endproperty
    a_sum_width: assert property (p_sum_width)
        else $error("checksum alert width out of range");
    property p_ref_gap; rise && (cmd == CMD_ACT || cmd == CMD_REF) |-> ref_q >= 10'h2; endproperty
    a_ref_gap: assert property (p_ref_gap)
        else $error("activate or refresh too soon after refresh");
    property p_persist_des;
        rise && persist_en && !alert_n && cmd != CMD_DES |-> al_q <= 10'h39;
    endproperty
    a_persist_des: assert property (p_persist_des)
        else $error("commands go on during persistent parity alert");

    // Main scenarios reached
    c_par: cover property (perr);
    c_sum: cover property (serr);
    c_lvl: cover property ($rose(dqs));
    c_ref: cover property (rise && cmd == CMD_REF);
endmodule

/* File: testbench.sv */
/*
 Testbench joining controller and device ends over one link.
 Assumes the package constants and the hand-over timing.
*/
`timescale 1ns/1ps
module testbench;
    import sal_pkg::*;
    localparam int NCK = 2 * CK_HALF;
    logic clk_sys, rst, req_valid, req_par_err, req_sum_err, persist_en;
    logic req_ready, done, done_err, lvl_result, exec_valid, lvl_active, alert_active;
    logic [CMD_W-1:0] req_cmd, exec_cmd;
    logic [DATA_W-1:0] req_wdata, exec_wdata, exec_d;
    logic [1:0] rfc_mode;
    logic [31:0] lfsr_q;
    int bad_count, tests_run, low_run, last_low, wait_n;
    logic [CMD_W-1:0] exp_cmd[$];
    logic [DATA_W-1:0] exp_data[$];
    logic [CMD_W-1:0] ops[4] = '{CMD_ACT, CMD_RD, CMD_WR, CMD_PRE};

    sal_link_if sal_link_if_i();
    sal_ctl sal_ctl_i(.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_cmd(req_cmd),
        .req_wdata(req_wdata), .req_par_err(req_par_err), .req_sum_err(req_sum_err),
        .rfc_mode(rfc_mode), .persist_en(persist_en), .link(sal_link_if_i),
        .req_ready(req_ready), .done(done), .done_err(done_err), .lvl_result(lvl_result));
    sal_dev sal_dev_i(.clk_sys(clk_sys), .rst(rst), .persist_en(persist_en),
        .link(sal_link_if_i), .exec_valid(exec_valid), .exec_cmd(exec_cmd),
        .exec_wdata(exec_wdata), .lvl_active(lvl_active), .alert_active(alert_active));
    sal_link_chk sal_link_chk_i(.clk_sys(clk_sys), .rst(rst), .persist_en(persist_en),
        .ck(sal_link_if_i.ck), .cmd(sal_link_if_i.cmd), .par(sal_link_if_i.par),
        .wdata(sal_link_if_i.wdata), .wsum(sal_link_if_i.wsum), .dqs(sal_link_if_i.dqs),
        .dqs_lvl(sal_link_if_i.dqs_lvl), .alert_n(sal_link_if_i.alert_n));

    // System clock
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Pseudo-random source
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A wait that ran out
    task automatic fail_out(input string what);
        bad_count++;
        $display("BAD timeout %s", what);
        test_done();
    endtask

    // Execution and alert length watch
    always @(negedge clk_sys) begin
        if (sal_link_if_i.alert_n === 1'b0) begin
            low_run++;
        end else if (low_run != 0) begin
            last_low = low_run;
            low_run = 0;
        end
        if (exec_valid === 1'b1) begin
            check("exec expected", exp_cmd.size() > 0, 1'h1);
            if (exp_cmd.size() > 0) begin
                exec_d = exp_data.pop_front();
                check("exec cmd", exec_cmd, exp_cmd.pop_front());
                if (exec_cmd === CMD_WR) check("exec data", exec_wdata, exec_d);
            end
        end
    end

    // One request, its completion and the expected execution
    task automatic req(input logic [CMD_W-1:0] c, input logic pe, input logic se,
            input logic err);
        int n;
        int base;
        base = (c == CMD_WLEV) ? LEVELING_FIRST_STROBE_WAIT + PARITY_LATENCY : PARITY_LATENCY + 1;
        lfsr_q = lfsr_next(lfsr_q);
        if (!pe && !se) begin
            exp_cmd.push_back(c);
            exp_data.push_back(lfsr_q[DATA_W-1:0]);
        end
        req_valid = 1'h1;
        req_cmd = c;
        req_wdata = lfsr_q[DATA_W-1:0];
        req_par_err = pe;
        req_sum_err = se;
        n = 0;
        while (req_ready !== 1'b1) begin
            @(negedge clk_sys);
            n++;
            if (n > 600) fail_out("ready");
        end
        wait_n = n;
        @(negedge clk_sys);
        req_valid = 1'h0;
        req_par_err = 1'h0;
        req_sum_err = 1'h0;
        n = 1;
        while (done !== 1'b1) begin
            @(negedge clk_sys);
            n++;
            if (n > 400) fail_out("done");
        end
        check("done_err", done_err, err);
        check("done time", n >= base * NCK && n <= (base + 3) * NCK, 1'h1);
        repeat (8) @(negedge clk_sys);
        check("exec left", exp_cmd.size(), 0);
    endtask

    // Wait for the alert to end and measure it
    task automatic alert_gone(input int lo, input int hi);
        int n;
        n = 0;
        while (sal_link_if_i.alert_n !== 1'b1) begin
            @(negedge clk_sys);
            n++;
            if (n > 600) fail_out("alert end");
        end
        repeat (2) @(negedge clk_sys);
        check("alert width", last_low >= lo && last_low <= hi, 1'h1);
        check("alert_active", alert_active, 1'h0);
    endtask

    // Main sequence
    initial begin
        rst = 1'h1;
        req_valid = 1'h0;
        req_cmd = CMD_DES;
        req_wdata = 8'h00;
        req_par_err = 1'h0;
        req_sum_err = 1'h0;
        rfc_mode = RFC_NORMAL;
        persist_en = 1'h0;
        lfsr_q = 32'h3557;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'h0;
        repeat (20) @(negedge clk_sys);
        // Plain commands with random data
        repeat (8) begin
            lfsr_q = lfsr_next(lfsr_q);
            req(ops[lfsr_q[1:0]], 1'h0, 1'h0, 1'h0);
        end
        // Refresh then activate in every granularity
        for (int m = 0; m < 4; m++) begin
            rfc_mode = m[1:0];
            req(CMD_REF, 1'h0, 1'h0, 1'h0);
            req(CMD_ACT, 1'h0, 1'h0, 1'h0);
        end
        // Write leveling entry, strobe, exit
        req(CMD_WLEV, 1'h0, 1'h0, 1'h0);
        check("lvl_active on", lvl_active, 1'h1);
        check("lvl_result", lvl_result, 1'h0);
        req(CMD_WLEX, 1'h0, 1'h0, 1'h0);
        check("lvl_active off", lvl_active, 1'h0);
        // Write with a bad checksum
        req(CMD_WR, 1'h0, 1'h1, 1'h1);
        alert_gone(CHECKSUM_ALERT_WIDTH_MIN * NCK, CHECKSUM_ALERT_WIDTH_MAX * NCK);
        // Bad parity then a read during the alert
        req(CMD_ACT, 1'h1, 1'h0, 1'h1);
        req(CMD_RD, 1'h0, 1'h0, 1'h1);
        alert_gone(PARITY_ALERT_WIDTH_MIN * NCK, PARITY_ALERT_WIDTH_MAX * NCK);
        // Persistent mode holds new work off during the alert
        persist_en = 1'h1;
        req(CMD_PRE, 1'h1, 1'h0, 1'h1);
        req(CMD_ACT, 1'h0, 1'h0, 1'h0);
        check("held off", wait_n >= (PARITY_ALERT_WIDTH_MIN - 8) * NCK, 1'h1);
        alert_gone(PARITY_ALERT_WIDTH_MIN * NCK, PARITY_ALERT_WIDTH_MAX * NCK);
        persist_en = 1'h0;
        repeat (10) @(negedge clk_sys);
        check("queue empty", exp_cmd.size(), 0);
        test_done();
    end
endmodule
